// ===== logic/etc_cal.sv
// Paged temperature calibration, self-heating model and current limit clamping
//
// Summary of operation
// - Working overcurrent fault threshold never below zero
// - Working reverse current threshold always strictly negative
// - Current threshold readback returns last written word
// - Separate sense gain tempco kept per page
// - Gain compensation uses same page diode temperature
// - Tempco word is signed ppm integer
// - Diode gain unsigned, two to minus fourteen
// - Temperature is kelvin times gain, offset applied
// - Invalid diode falls back to die temperature
// - Four paged temperature limits supervised per channel
// - Read-only per-page self-heating rise value
// - Per-page inverse thermal time constant held
// - Per-page thermal resistance held
// - Correction factor clamped between quarter and four
// - Self-heating rise confined to zero..fifty degrees
`timescale 1ns/10ps
`default_nettype none
`include "etc_regs.svh"

module etc_cal
  import etc_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  input  wire logic              i_wr_en,
  input  wire logic              i_rd_en,
  input  wire logic [1:0]        i_page,
  input  wire logic [7:0]        i_cmd,
  input  wire logic [15:0]       i_wdata,
  input  wire logic              i_meas_valid,
  input  wire etc_meas_t         i_meas,
  output logic [15:0]            o_rdata,
  output logic                   o_rvalid,
  output logic                   o_cmd_err,
  output logic                   o_stat_valid,
  output etc_stat_t              o_stat,
  output etc_flags_t [3:0]       o_flags,
  output logic [3:0][31:0]       o_oc_fault_work,
  output logic [3:0][31:0]       o_uc_fault_work
);

  // --------------------------------------------------------------------------
  // Linear word decode to fixed point with fb fraction bits
  // --------------------------------------------------------------------------
  function automatic logic signed [31:0] etc_l11(input logic [15:0] w, input int fb);
    logic signed [4:0]  e;
    logic signed [31:0] m;
    int                 s;
    e = w[`ETC_L11_EXP_MSB:`ETC_L11_EXP_LSB];
    m = 32'(signed'(w[`ETC_L11_MAN_MSB:0]));
    s = int'(e) + fb;
    // Cap keeps a large exponent inside 32 bits
    if (s > 20) begin
      s = 20;
    end
    if (s >= 0) begin
      etc_l11 = m <<< s;
    end else begin
      etc_l11 = m >>> (-s);
    end
  endfunction : etc_l11

  // --------------------------------------------------------------------------
  // Per-page command words
  // --------------------------------------------------------------------------
  logic [15:0]        oc_fault_q  [4];
  logic [15:0]        oc_warn_q   [4];
  logic [15:0]        uc_fault_q  [4];
  logic [15:0]        ot_fault_q  [4];
  logic [15:0]        ot_warn_q   [4];
  logic [15:0]        ut_warn_q   [4];
  logic [15:0]        ut_fault_q  [4];
  logic [15:0]        tau_q       [4];
  logic [15:0]        theta_q     [4];
  logic [15:0]        tempco_q    [4];
  logic [15:0]        gain_q      [4];
  logic [15:0]        offset_q    [4];
  logic signed [31:0] self_heat_q [4];

  // Pipeline stage 1: calibrated temperature
  logic               s1_valid_q;
  logic [1:0]         s1_page_q;
  logic signed [31:0] s1_temp_q;
  logic signed [15:0] s1_power_q;

  // Stage 2 combinational results
  logic signed [31:0] s2_sh_d;
  logic [15:0]        s2_corr_d;
  etc_flags_t         s2_flags_d;

  logic               wr_ok;
  logic               cmd_known;

  // --------------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------------
  // Codes outside this list are refused
  always_comb begin
    case (i_cmd)
      `ETC_CMD_OC_FAULT, `ETC_CMD_OC_WARN, `ETC_CMD_UC_FAULT,
      `ETC_CMD_OT_FAULT, `ETC_CMD_OT_WARN, `ETC_CMD_UT_WARN,
      `ETC_CMD_UT_FAULT, `ETC_CMD_SELF_HEAT, `ETC_CMD_TAU_INV,
      `ETC_CMD_THETA, `ETC_CMD_TEMPCO, `ETC_CMD_DIODE_GAIN,
      `ETC_CMD_DIODE_OFFSET: begin
        cmd_known = 1'b1;
      end
      default: begin
        cmd_known = 1'b0;
      end
    endcase
  end

  // Self-heating rise cannot be written
  assign wr_ok = i_wr_en && cmd_known && (i_cmd != `ETC_CMD_SELF_HEAT);

  // --------------------------------------------------------------------------
  // Per-page register file and working limits
  // --------------------------------------------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_page
    logic sel;
    logic signed [31:0] wval;
    assign sel  = wr_ok && (i_page == 2'(g));
    assign wval = etc_l11(i_wdata, `ETC_TEMP_FB);

    always_ff @(posedge i_mclk) begin
      if (i_rst) begin
        oc_fault_q[g] <= `ETC_RST_OC_FAULT;
        oc_warn_q[g]  <= `ETC_RST_OC_WARN;
        uc_fault_q[g] <= `ETC_RST_UC_FAULT;
        ot_fault_q[g] <= `ETC_RST_OT_FAULT;
        ot_warn_q[g]  <= `ETC_RST_OT_WARN;
        ut_warn_q[g]  <= `ETC_RST_UT_WARN;
        ut_fault_q[g] <= `ETC_RST_UT_FAULT;
        tau_q[g]      <= `ETC_RST_TAU_INV;
        theta_q[g]    <= `ETC_RST_THETA;
        tempco_q[g]   <= `ETC_RST_TEMPCO;
        gain_q[g]     <= `ETC_RST_DIODE_GAIN;
        offset_q[g]   <= `ETC_RST_DIODE_OFFSET;
      end else if (sel) begin
        case (i_cmd)
          `ETC_CMD_OC_FAULT:     oc_fault_q[g] <= i_wdata;
          `ETC_CMD_OC_WARN:      oc_warn_q[g]  <= i_wdata;
          `ETC_CMD_UC_FAULT:     uc_fault_q[g] <= i_wdata;
          `ETC_CMD_OT_FAULT:     ot_fault_q[g] <= i_wdata;
          `ETC_CMD_OT_WARN:      ot_warn_q[g]  <= i_wdata;
          `ETC_CMD_UT_WARN:      ut_warn_q[g]  <= i_wdata;
          `ETC_CMD_UT_FAULT:     ut_fault_q[g] <= i_wdata;
          `ETC_CMD_TAU_INV:      tau_q[g]      <= i_wdata;
          `ETC_CMD_THETA:        theta_q[g]    <= i_wdata;
          `ETC_CMD_TEMPCO:       tempco_q[g]   <= i_wdata;
          `ETC_CMD_DIODE_GAIN:   gain_q[g]     <= i_wdata;
          `ETC_CMD_DIODE_OFFSET: offset_q[g]   <= i_wdata;
          default: begin
          end
        endcase
      end
    end

    // Working thresholds in sixteenths of an ampere
    // Readback words keep the raw value; only these copies clamp
    always_ff @(posedge i_mclk) begin
      if (i_rst) begin
        o_oc_fault_work[g] <= 32'h000000A0;
        o_uc_fault_work[g] <= 32'hFFFFFFF0;
      end else if (sel && i_cmd == `ETC_CMD_OC_FAULT) begin
        o_oc_fault_work[g] <= (wval < 0) ? 32'h00000000 : wval;
      end else if (sel && i_cmd == `ETC_CMD_UC_FAULT) begin
        o_uc_fault_work[g] <= (wval >= 0) ? 32'hFFFFFFFF : wval;
      end
    end

    // Self-heating estimate, zero at start
    always_ff @(posedge i_mclk) begin
      if (i_rst) begin
        self_heat_q[g] <= 32'sh00000000;
      end else if (s1_valid_q && s1_page_q == 2'(g)) begin
        self_heat_q[g] <= s2_sh_d;
      end
    end

    // Limit flags of this page
    always_ff @(posedge i_mclk) begin
      if (i_rst) begin
        o_flags[g] <= '0;
      end else if (s1_valid_q && s1_page_q == 2'(g)) begin
        o_flags[g] <= s2_flags_d;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register readback
  // --------------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rdata  <= 16'h0000;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd_en && cmd_known;
      if (i_rd_en) begin
        case (i_cmd)
          `ETC_CMD_OC_FAULT:     o_rdata <= oc_fault_q[i_page];
          `ETC_CMD_OC_WARN:      o_rdata <= oc_warn_q[i_page];
          `ETC_CMD_UC_FAULT:     o_rdata <= uc_fault_q[i_page];
          `ETC_CMD_OT_FAULT:     o_rdata <= ot_fault_q[i_page];
          `ETC_CMD_OT_WARN:      o_rdata <= ot_warn_q[i_page];
          `ETC_CMD_UT_WARN:      o_rdata <= ut_warn_q[i_page];
          `ETC_CMD_UT_FAULT:     o_rdata <= ut_fault_q[i_page];
          // Rise returned as a linear word, exponent fixed
          `ETC_CMD_SELF_HEAT:    o_rdata <= {`ETC_L11_EXP_SIXTEENTH,
                                             self_heat_q[i_page][10:0]};
          `ETC_CMD_TAU_INV:      o_rdata <= tau_q[i_page];
          `ETC_CMD_THETA:        o_rdata <= theta_q[i_page];
          `ETC_CMD_TEMPCO:       o_rdata <= tempco_q[i_page];
          `ETC_CMD_DIODE_GAIN:   o_rdata <= gain_q[i_page];
          `ETC_CMD_DIODE_OFFSET: o_rdata <= offset_q[i_page];
          default:               o_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Unknown command or write to the read-only word
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_cmd_err <= 1'b0;
    end else begin
      o_cmd_err <= ((i_rd_en || i_wr_en) && !cmd_known) ||
                   (i_wr_en && i_cmd == `ETC_CMD_SELF_HEAT);
    end
  end

  // --------------------------------------------------------------------------
  // Stage 1: diode temperature calibration
  // --------------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s1_valid_q <= 1'b0;
      s1_page_q  <= 2'h0;
      s1_temp_q  <= 32'sh00000000;
      s1_power_q <= 16'sh0000;
    end else begin
      s1_valid_q <= i_meas_valid;
      if (i_meas_valid) begin
        s1_page_q  <= i_meas.page;
        s1_power_q <= i_meas.power;
        if (i_meas.sense_ok) begin
          // Sixteenths of a kelvin times gain, minus the ice point
          s1_temp_q <= 32'(signed'({1'b0, 32'({16'h0000, i_meas.kelvin} *
                                              {16'h0000, gain_q[i_meas.page]})
                                   >> `ETC_GAIN_SHIFT}))
                       - `ETC_KELVIN_OFS
                       + etc_l11(offset_q[i_meas.page], `ETC_TEMP_FB);
        end else begin
          // Die temperature, gain and offset ignored
          s1_temp_q <= 32'(i_meas.die_temp);
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Stage 2: self-heating model
  // --------------------------------------------------------------------------
  always_comb begin
    logic signed [31:0] tau;
    logic signed [31:0] theta;
    logic signed [31:0] target;
    logic signed [47:0] prod;
    tau    = etc_l11(tau_q[s1_page_q], `ETC_TAU_FB);
    theta  = etc_l11(theta_q[s1_page_q], `ETC_TEMP_FB);
    prod   = 48'(s1_power_q) * 48'(theta);
    target = 32'(prod >>> `ETC_TEMP_FB);
    if (tau <= 0 || theta <= 0) begin
      s2_sh_d = 32'sh00000000;
    end else if (tau >= `ETC_CORR_ONE) begin
      s2_sh_d = target;
    end else begin
      // Partial step toward the steady-state rise
      prod    = 48'(target - self_heat_q[s1_page_q]) * 48'(tau);
      s2_sh_d = self_heat_q[s1_page_q] + 32'(prod >>> `ETC_TAU_FB);
    end
    if (s2_sh_d < 0) begin
      s2_sh_d = 32'sh00000000;
    end else if (s2_sh_d > `ETC_SELF_HEAT_MAX) begin
      s2_sh_d = `ETC_SELF_HEAT_MAX;
    end
  end

  // --------------------------------------------------------------------------
  // Stage 2: sense gain correction
  // --------------------------------------------------------------------------
  always_comb begin
    logic signed [31:0] dt;
    logic signed [47:0] prod;
    logic signed [31:0] corr;
    // Same-page temperature drives the tempco term
    dt   = s1_temp_q + s2_sh_d - `ETC_TC_REF_TEMP;
    prod = 48'(signed'(tempco_q[s1_page_q])) * 48'(dt);
    prod = prod * `ETC_PPM_SCALE;
    corr = `ETC_CORR_ONE + 32'(prod >>> `ETC_PPM_SHIFT);
    if (corr < `ETC_CORR_MIN) begin
      corr = `ETC_CORR_MIN;
    end else if (corr > `ETC_CORR_MAX) begin
      corr = `ETC_CORR_MAX;
    end
    s2_corr_d = corr[15:0];
  end

  // --------------------------------------------------------------------------
  // Stage 2: limit supervision
  // --------------------------------------------------------------------------
  always_comb begin
    s2_flags_d.ot_fault = s1_temp_q > etc_l11(ot_fault_q[s1_page_q], `ETC_TEMP_FB);
    s2_flags_d.ot_warn  = s1_temp_q > etc_l11(ot_warn_q[s1_page_q], `ETC_TEMP_FB);
    s2_flags_d.ut_warn  = s1_temp_q < etc_l11(ut_warn_q[s1_page_q], `ETC_TEMP_FB);
    s2_flags_d.ut_fault = s1_temp_q < etc_l11(ut_fault_q[s1_page_q], `ETC_TEMP_FB);
  end

  // --------------------------------------------------------------------------
  // Status output
  // --------------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_stat_valid <= 1'b0;
      o_stat       <= '0;
    end else begin
      o_stat_valid <= s1_valid_q;
      if (s1_valid_q) begin
        o_stat.page      <= s1_page_q;
        o_stat.temp      <= s1_temp_q;
        o_stat.self_heat <= s2_sh_d;
        o_stat.tcorr     <= s2_corr_d;
      end
    end
  end

endmodule : etc_cal

`default_nettype wire

// ===== logic/etc_regs.svh
// Command codes, reset values and fixed-point constants of the calibration block
`ifndef ETC_REGS_SVH
`define ETC_REGS_SVH

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define ETC_CMD_OC_FAULT      8'h46
`define ETC_CMD_OC_WARN       8'h4A
`define ETC_CMD_UC_FAULT      8'h4B
`define ETC_CMD_OT_FAULT      8'h4F
`define ETC_CMD_OT_WARN       8'h51
`define ETC_CMD_UT_WARN       8'h52
`define ETC_CMD_UT_FAULT      8'h53
`define ETC_CMD_SELF_HEAT     8'hB8
`define ETC_CMD_TAU_INV       8'hB9
`define ETC_CMD_THETA         8'hBA
`define ETC_CMD_TEMPCO        8'hF6
`define ETC_CMD_DIODE_GAIN    8'hF8
`define ETC_CMD_DIODE_OFFSET  8'hF9

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ETC_RST_OC_FAULT      16'hD280
`define ETC_RST_OC_WARN       16'hCA80
`define ETC_RST_UC_FAULT      16'hB400
`define ETC_RST_OT_FAULT      16'hEA08
`define ETC_RST_OT_WARN       16'hE3C0
`define ETC_RST_UT_WARN       16'h8000
`define ETC_RST_UT_FAULT      16'hCD80
`define ETC_RST_TAU_INV       16'h8000
`define ETC_RST_THETA         16'h8000
`define ETC_RST_TEMPCO        16'h0000
`define ETC_RST_DIODE_GAIN    16'h4000
`define ETC_RST_DIODE_OFFSET  16'h8000

// ----------------------------------------------------------------------------
// Field positions and fixed-point figures
// ----------------------------------------------------------------------------
`define ETC_L11_EXP_MSB       15
`define ETC_L11_EXP_LSB       11
`define ETC_L11_MAN_MSB       10
`define ETC_L11_EXP_SIXTEENTH 5'h1C
`define ETC_TEMP_FB           4
`define ETC_TAU_FB            12
`define ETC_GAIN_SHIFT        14
`define ETC_KELVIN_OFS        32'sh00001112
`define ETC_TC_REF_TEMP       32'sh00000190
`define ETC_SELF_HEAT_MAX     32'sh00000320
`define ETC_CORR_ONE          32'sh00001000
`define ETC_CORR_MIN          32'sh00000400
`define ETC_CORR_MAX          32'sh00004000
`define ETC_PPM_SCALE         48'sh00000000010C
`define ETC_PPM_SHIFT         20

`endif

// ===== logic/etc_pkg.sv
// Types shared by the external temperature and current limit calibration block
package etc_pkg;

  // --------------------------------------------------------------------------
  // Measurement and result carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]         page;
    logic [15:0]        kelvin;
    logic               sense_ok;
    logic signed [15:0] die_temp;
    logic signed [15:0] power;
  } etc_meas_t;

  typedef struct packed {
    logic [1:0]         page;
    logic signed [31:0] temp;
    logic signed [31:0] self_heat;
    logic [15:0]        tcorr;
  } etc_stat_t;

  typedef struct packed {
    logic ot_fault;
    logic ot_warn;
    logic ut_warn;
    logic ut_fault;
  } etc_flags_t;

endpackage : etc_pkg

// ===== dv/etc_cal_assertions.sv
// Concurrent checks on the calibration block ports
`timescale 1ns/10ps
`default_nettype none
module etc_cal_assertions
  import etc_pkg::*;
(
  input wire logic             i_mclk,
  input wire logic             i_rst,
  input wire logic             i_wr_en,
  input wire logic             i_rd_en,
  input wire logic [1:0]       i_page,
  input wire logic [7:0]       i_cmd,
  input wire logic [15:0]      i_wdata,
  input wire logic             i_meas_valid,
  input wire etc_meas_t        i_meas,
  input wire logic [15:0]      o_rdata,
  input wire logic             o_rvalid,
  input wire logic             o_cmd_err,
  input wire logic             o_stat_valid,
  input wire etc_stat_t        o_stat,
  input wire logic [3:0][31:0] o_oc_fault_work,
  input wire logic [3:0][31:0] o_uc_fault_work
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  // --------------------------------------------------------------------------
  // Command port
  // --------------------------------------------------------------------------
  property p_oc_clamp;
    i_wr_en && i_cmd == 8'h46 && i_wdata[10] |=> o_oc_fault_work[$past(i_page)] == 32'h0;
  endproperty
  a_oc_clamp: assert property (p_oc_clamp) else $error("negative OC limit not clamped");
  property p_uc_clamp;
    i_wr_en && i_cmd == 8'h4B && !i_wdata[10] |=> o_uc_fault_work[$past(i_page)] == 32'hFFFFFFFF;
  endproperty
  a_uc_clamp: assert property (p_uc_clamp) else $error("non-negative UC limit not clamped");
  property p_rd_echo;
    i_wr_en && i_cmd == 8'h46 ##1 !i_wr_en ##1 i_rd_en && i_cmd == 8'h46 && i_page == $past(i_page, 2)
      |=> o_rdata == $past(i_wdata, 3);
  endproperty
  a_rd_echo: assert property (p_rd_echo) else $error("readback differs from written word");
  property p_rvalid_cause;
    o_rvalid |-> $past(i_rd_en);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause) else $error("read valid without read");
  property p_rdata_hold;
    !$past(i_rd_en) |-> $stable(o_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read word changed without read");
  property p_ro_self_heat;
    i_wr_en && i_cmd == 8'hB8 |=> o_cmd_err && !o_rvalid;
  endproperty
  a_ro_self_heat: assert property (p_ro_self_heat) else $error("write to read-only word accepted");

  // --------------------------------------------------------------------------
  // Measurement port
  // --------------------------------------------------------------------------
  property p_stat_lat;
    i_meas_valid |-> ##2 o_stat_valid && o_stat.page == $past(i_meas.page, 2);
  endproperty
  a_stat_lat: assert property (p_stat_lat) else $error("status late or wrong page");
  property p_fallback;
    i_meas_valid && !i_meas.sense_ok |-> ##2 o_stat.temp == $past(i_meas.die_temp, 2);
  endproperty
  a_fallback: assert property (p_fallback) else $error("die temperature not substituted");
  property p_sh_range;
    o_stat_valid |-> !o_stat.self_heat[31] && o_stat.self_heat <= 32'sh320;
  endproperty
  a_sh_range: assert property (p_sh_range) else $error("self heat out of range");
  property p_tcorr_range;
    o_stat_valid |-> o_stat.tcorr >= 16'h400 && o_stat.tcorr <= 16'h4000;
  endproperty
  a_tcorr_range: assert property (p_tcorr_range) else $error("correction out of range");

  c_sh_max: cover property (o_stat_valid && o_stat.self_heat == 32'sh320);
  c_tcorr_min: cover property (o_stat_valid && o_stat.tcorr == 16'h400);
  c_fallback: cover property (i_meas_valid && !i_meas.sense_ok);
endmodule : etc_cal_assertions

bind etc_cal etc_cal_assertions i_chk (.i_mclk(i_mclk), .i_rst(i_rst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
  .i_page(i_page), .i_cmd(i_cmd), .i_wdata(i_wdata), .i_meas_valid(i_meas_valid), .i_meas(i_meas),
  .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_cmd_err(o_cmd_err), .o_stat_valid(o_stat_valid),
  .o_stat(o_stat), .o_oc_fault_work(o_oc_fault_work), .o_uc_fault_work(o_uc_fault_work));
`default_nettype wire

// ===== dv/etc_host_model.sv
// Host model issuing word commands
`timescale 1ns/10ps
`default_nettype none
module etc_host_model (
  input  wire logic        i_mclk,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_rvalid,
  input  wire logic        i_cmd_err,
  output var logic         o_wr_en,
  output var logic         o_rd_en,
  output var logic [1:0]   o_page,
  output var logic [7:0]   o_cmd,
  output var logic [15:0]  o_wdata
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_page = 2'h0;
    o_cmd = 8'hFF;
    o_wdata = 16'hA5A5;
  end

  // One word access, lines scrambled once idle
  task automatic access(input logic wr, input logic [1:0] pg, input logic [7:0] cmd, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ok, output logic err);
    @(posedge i_mclk);
    o_wr_en <= wr;
    o_rd_en <= ~wr;
    o_page <= pg;
    o_cmd <= cmd;
    o_wdata <= wd;
    @(posedge i_mclk);
    o_wr_en <= 1'b0;
    o_rd_en <= 1'b0;
    o_page <= ~pg;
    o_cmd <= ~cmd;
    o_wdata <= ~wd;
    #1;
    rd = i_rdata;
    ok = i_rvalid;
    err = i_cmd_err;
  endtask : access
endmodule : etc_host_model
`default_nettype wire

// ===== dv/etc_cal_bench.sv
// Self-checking bench for the calibration block
`timescale 1ns/10ps
`default_nettype none
module etc_cal_bench
  import etc_pkg::*;
;
  logic             i_mclk = 1'b0;
  logic             i_rst = 1'b1;
  logic             i_meas_valid = 1'b0;
  etc_meas_t        i_meas = '0;
  logic             i_wr_en;
  logic             i_rd_en;
  logic [1:0]       i_page;
  logic [7:0]       i_cmd;
  logic [15:0]      i_wdata;
  logic [15:0]      o_rdata;
  logic             o_rvalid;
  logic             o_cmd_err;
  logic             o_stat_valid;
  etc_stat_t        o_stat;
  etc_flags_t [3:0] o_flags;
  logic [3:0][31:0] oc_work;
  logic [3:0][31:0] uc_work;
  int               err_total = 0;
  int               tests_run = 0;
  logic [7:0]       rst_cmd [13] = '{8'h4F, 8'h51, 8'h52, 8'h53, 8'hB9, 8'hBA, 8'hF8, 8'hF9, 8'hF6, 8'hB8,
                                     8'h46, 8'h4A, 8'h4B};
  logic [15:0]      rst_val [13] = '{16'hEA08, 16'hE3C0, 16'h8000, 16'hCD80, 16'h8000, 16'h8000, 16'h4000,
                                     16'h8000, 16'h0000, 16'hE000, 16'hD280, 16'hCA80, 16'hB400};

  always #25 i_mclk = ~i_mclk;

  etc_cal i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_page(i_page),
    .i_cmd(i_cmd), .i_wdata(i_wdata), .i_meas_valid(i_meas_valid), .i_meas(i_meas), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .o_cmd_err(o_cmd_err), .o_stat_valid(o_stat_valid), .o_stat(o_stat),
    .o_flags(o_flags), .o_oc_fault_work(oc_work), .o_uc_fault_work(uc_work));

  etc_host_model i_host (.i_mclk(i_mclk), .i_rdata(o_rdata), .i_rvalid(o_rvalid), .i_cmd_err(o_cmd_err),
    .o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_page(i_page), .o_cmd(i_cmd), .o_wdata(i_wdata));

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [1:0] pg, input logic [7:0] cmd, input logic [15:0] wd, input logic xe);
    logic [15:0] rd;
    logic ok;
    logic err;
    i_host.access(1'b1, pg, cmd, wd, rd, ok, err);
    check({31'h0, err}, {31'h0, xe});
  endtask : wr

  task automatic rd(input logic [1:0] pg, input logic [7:0] cmd, input logic [15:0] xd, input logic xok);
    logic [15:0] d;
    logic ok;
    logic err;
    i_host.access(1'b0, pg, cmd, 16'h0, d, ok, err);
    check({16'h0, d}, {16'h0, xd});
    check({31'h0, ok}, {31'h0, xok});
    check({31'h0, err}, {31'h0, ~xok});
  endtask : rd

  task automatic meas(input logic [1:0] pg, input logic [15:0] kel, input logic ok, input logic [15:0] die,
                      input logic [15:0] pw, input logic [31:0] t, input logic [3:0] fl, input logic [31:0] sh,
                      input logic [15:0] tc);
    @(posedge i_mclk);
    i_meas_valid <= 1'b1;
    i_meas <= '{pg, kel, ok, die, pw};
    @(posedge i_mclk);
    i_meas_valid <= 1'b0;
    i_meas <= ~i_meas;
    @(posedge i_mclk);
    #1;
    check({31'h0, o_stat_valid}, 32'h1);
    check({30'h0, o_stat.page}, {30'h0, pg});
    check(o_stat.temp, t);
    check({28'h0, o_flags[pg]}, {28'h0, fl});
    check(o_stat.self_heat, sh);
    check({16'h0, o_stat.tcorr}, {16'h0, tc});
  endtask : meas

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  // --------------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    foreach (rst_cmd[k]) begin
      rd(2'h3, rst_cmd[k], rst_val[k], 1'b1);
    end
    check(oc_work[0], 32'hA0);
    check(uc_work[0], 32'hFFFFFFF0);
    wr(2'h1, 8'h46, 16'hB400, 1'b0);
    check(oc_work[1], 32'h0);
    rd(2'h1, 8'h46, 16'hB400, 1'b1);
    wr(2'h1, 8'h46, 16'hD280, 1'b0);
    check(oc_work[1], 32'hA0);
    wr(2'h2, 8'h4B, 16'h0000, 1'b0);
    check(uc_work[2], 32'hFFFFFFFF);
    rd(2'h2, 8'h4B, 16'h0000, 1'b1);
    wr(2'h0, 8'hB8, 16'h1234, 1'b1);
    rd(2'h0, 8'hB8, 16'hE000, 1'b1);
    rd(2'h0, 8'h00, 16'h0000, 1'b0);
    // Page 0: gain, limits, signed tempco and correction clamp
    meas(2'h0, 16'h12A2, 1'b1, 16'h0, 16'h0, 32'h190, 4'h0, 32'h0, 16'h1000);
    wr(2'h0, 8'hF8, 16'h8000, 1'b0);
    meas(2'h0, 16'h12A2, 1'b1, 16'h0, 16'h0, 32'h1432, 4'hC, 32'h0, 16'h1000);
    meas(2'h0, 16'h0A7D, 1'b1, 16'h0, 16'h0, 32'h3E8, 4'h4, 32'h0, 16'h1000);
    wr(2'h0, 8'hF6, 16'h7FFF, 1'b0);
    meas(2'h0, 16'h12A2, 1'b1, 16'h0, 16'h0, 32'h1432, 4'hC, 32'h0, 16'h4000);
    wr(2'h0, 8'hF6, 16'h8000, 1'b0);
    meas(2'h0, 16'h12A2, 1'b1, 16'h0, 16'h0, 32'h1432, 4'hC, 32'h0, 16'h0400);
    // Page 1: invalid diode ignores gain and offset
    wr(2'h1, 8'hF8, 16'h8000, 1'b0);
    wr(2'h1, 8'hF9, 16'hF808, 1'b0);
    meas(2'h1, 16'h12A2, 1'b0, 16'hFF38, 16'h0, 32'hFFFFFF38, 4'h3, 32'h0, 16'h1000);
    meas(2'h1, 16'h12A2, 1'b0, 16'hFFF0, 16'h0, 32'hFFFFFFF0, 4'h2, 32'h0, 16'h1000);
    // Page 3: offset with negative exponent adds 4 C, then a paged 25 C limit
    wr(2'h3, 8'hF9, 16'hF808, 1'b0);
    meas(2'h3, 16'h12A2, 1'b1, 16'h0, 16'h0, 32'h1D0, 4'h0, 32'h0, 16'h1000);
    wr(2'h3, 8'h4F, 16'h0019, 1'b0);
    meas(2'h3, 16'h12A2, 1'b1, 16'h0, 16'h0, 32'h1D0, 4'h8, 32'h0, 16'h1000);
    // Page 2: self heating direct, clamped, disabled and half step
    wr(2'h2, 8'hB9, 16'h0001, 1'b0);
    wr(2'h2, 8'hBA, 16'h0064, 1'b0);
    meas(2'h2, 16'h12A2, 1'b1, 16'h0, 16'h10, 32'h190, 4'h0, 32'h320, 16'h1000);
    rd(2'h2, 8'hB8, 16'hE320, 1'b1);
    meas(2'h2, 16'h12A2, 1'b1, 16'h0, 16'h4, 32'h190, 4'h0, 32'h190, 16'h1000);
    wr(2'h2, 8'hB9, 16'h8000, 1'b0);
    meas(2'h2, 16'h12A2, 1'b1, 16'h0, 16'h10, 32'h190, 4'h0, 32'h0, 16'h1000);
    wr(2'h2, 8'hB9, 16'hF801, 1'b0);
    meas(2'h2, 16'h12A2, 1'b1, 16'h0, 16'h4, 32'h190, 4'h0, 32'hC8, 16'h1000);
    meas(2'h2, 16'h12A2, 1'b1, 16'h0, 16'h4, 32'h190, 4'h0, 32'h12C, 16'h1000);
    print_verdict();
  end

  initial begin
    repeat (2000) @(posedge i_mclk);
    err_total++;
    print_verdict();
  end
endmodule : etc_cal_bench
`default_nettype wire
